// *** hw/vrt_pkg.sv ***
// Purpose: Shared constants for the raster timing register block
// Assumes: 32-bit APB register window, one pixel per clock
// Notes: Timing register codes ride in the top byte of a data port write
package vrt_pkg;
  // APB byte offsets
  localparam logic [11:0] DATA_OFF = 12'h000;
  localparam logic [11:0] CTRL_OFF = 12'h004;
  localparam logic [11:0] STAT_OFF = 12'h008;
  // Register codes carried in the write word
  localparam int SEL_LSB = 24;
  localparam logic [7:0] SEL_LINE_PERIOD = 8'h80;
  localparam logic [7:0] SEL_BORDER_START = 8'h82;
  localparam logic [7:0] SEL_DISPLAY_START = 8'h83;
  localparam logic [7:0] SEL_DISPLAY_END = 8'h84;
  localparam logic [7:0] SEL_BORDER_END = 8'h85;
  localparam logic [7:0] SEL_CURSOR_START = 8'h86;
  localparam logic [7:0] SEL_INTERLACE_RSVD = 8'h87;
  localparam logic [7:0] SEL_TEST_A = 8'h88;
  localparam logic [7:0] SEL_TEST_B = 8'h89;
  localparam logic [7:0] SEL_FRAME_CYCLE = 8'h90;
  // Field widths
  localparam int HW = 14;
  localparam int VW = 13;
  localparam int HCW = 15;
  localparam int VCW = 14;
  // Control bit positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_HIGH_RESOLUTION_MODE_BIT = 1;
  localparam int CTRL_ILACE_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // Status field positions
  localparam int STAT_H_LSB = 0;
  localparam int STAT_V_LSB = 16;
  localparam int STAT_FIELD_BIT = 31;
  // Reset value of every timing register
  localparam logic [HW-1:0] HREG_RESET = 14'h0000;
  localparam logic [VW-1:0] VREG_RESET = 13'h0000;
  // Programming offsets, in pixels or rasters
  localparam logic [HCW-1:0] LINE_OFS = 15'h0007;
  localparam logic [HCW-1:0] BORDER_OFS = 15'h000C;
  localparam logic [HCW-1:0] DISPLAY_OFS = 15'h0012;
  localparam logic [HCW-1:0] CURSOR_OFS = 15'h0011;
  localparam logic [VCW-1:0] FRAME_OFS = 14'h0001;
  // Automatic cursor widths
  localparam logic [5:0] CURSOR_W_NORMAL = 6'h20;
  localparam logic [5:0] CURSOR_W_HIGH_RESOLUTION_MODE = 6'h10;
endpackage : vrt_pkg

// *** hw/vrt_counter.sv ***
// Purpose: Wrapping position counter for pixels or rasters
// Assumes: Terminal value is the last count of the period
// Notes: Counts only while step_i is high
`timescale 1ns/10ps
module vrt_counter #(
  parameter int W = 15
) (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Synchronised reset, active low
  input wire logic run_i, // Counter enabled
  input wire logic step_i, // Advance one position
  input wire logic [W-1:0] last_i, // Last count of the period
  output logic [W-1:0] count_o, // Current position
  output logic wrap_o // Step from last back to zero
);
  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  wire at_last = (count_q >= last_i);

  // Wrap also when a shorter period was loaded mid-scan
  assign wrap_o = run_i & step_i & at_last;
  assign count_d = !run_i ? '0 : !step_i ? count_q : at_last ? '0 : count_q + W'(1);
  assign count_o = count_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end
endmodule : vrt_counter

// *** hw/vrt_cursor.sv ***
// Purpose: Horizontal cursor window of automatic width
// Assumes: Start position is the programmed value plus its offset
// Notes: Width follows the resolution mode at cursor start
`timescale 1ns/10ps
module vrt_cursor (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Synchronised reset, active low
  input wire logic run_i, // Timing enabled
  input wire logic [vrt_pkg::HCW-1:0] hcount_i, // Pixel position in line
  input wire logic [vrt_pkg::HCW-1:0] start_i, // First cursor pixel
  input wire logic high_resolution_mode_i, // High resolution mode
  output logic active_o // Cursor window open
);
  logic [5:0] left_q;
  logic [5:0] left_d;
  wire hit = run_i & (hcount_i == start_i);
  wire [5:0] width = high_resolution_mode_i ? vrt_pkg::CURSOR_W_HIGH_RESOLUTION_MODE : vrt_pkg::CURSOR_W_NORMAL;

  assign left_d = !run_i ? 6'h00 : hit ? width - 6'h01 : (left_q != 6'h00) ? left_q - 6'h01 :
    6'h00;
  assign active_o = hit | (left_q != 6'h00);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left_q <= 6'h00;
    end else begin
      left_q <= left_d;
    end
  end
endmodule : vrt_cursor

// *** hw/vrt_timing.sv ***
// Purpose: Raster timing registers and compare logic behind an APB slave
// Assumes: One pixel per clock; sync width and vertical windows live elsewhere
// Notes: Timing registers are written through one data port, code in top byte
// Notes on behaviour
// - border starts at stored value plus 12
// - display starts at stored value plus 18
// - display ends at stored value plus 18
// - border ends at stored value plus 12
// - cursor starts at stored value plus 17
// - cursor lasts 32 pixels, 16 in high_resolution_mode
// - high_resolution_mode cursor starts on normal pixels
// - non-interlaced frame length is stored value plus 2
// - line length is stored value plus 8
`timescale 1ns/10ps
module vrt_timing (
  input wire logic clk_i, // Clock, 40 MHz
  input wire logic resetn_i, // Asynchronous reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [11:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error
  output logic line_start_o, // First pixel of line
  output logic border_o, // Border window
  output logic display_o, // Active video window
  output logic cursor_o, // Cursor window
  output logic frame_start_o, // First raster of field
  output logic field_odd_o, // Second field of interlaced frame
  output logic [vrt_pkg::HCW-1:0] hcount_o, // Pixel position
  output logic [vrt_pkg::VCW-1:0] vcount_o // Raster position
);
  // Reset release
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // APB decode
  wire setup = psel_i & ~penable_i;
  wire access = psel_i & penable_i & pready_o;
  wire hit_data = (paddr_i == vrt_pkg::DATA_OFF);
  wire hit_ctrl = (paddr_i == vrt_pkg::CTRL_OFF);
  wire hit_stat = (paddr_i == vrt_pkg::STAT_OFF);
  wire mapped = hit_data | hit_ctrl | (hit_stat & ~pwrite_i);
  wire wr_data = access & pwrite_i & hit_data;
  wire wr_ctrl = access & pwrite_i & hit_ctrl;
  wire [7:0] sel = pwdata_i[vrt_pkg::SEL_LSB +: 8];
  wire [vrt_pkg::HW-1:0] wval_h = pwdata_i[vrt_pkg::HW-1:0];
  wire [vrt_pkg::VW-1:0] wval_v = pwdata_i[vrt_pkg::VW-1:0];

  // Timing registers
  logic [vrt_pkg::HW-1:0] line_period_q;
  logic [vrt_pkg::HW-1:0] border_start_q;
  logic [vrt_pkg::HW-1:0] display_start_q;
  logic [vrt_pkg::HW-1:0] display_end_q;
  logic [vrt_pkg::HW-1:0] border_end_q;
  logic [vrt_pkg::HW-1:0] cursor_start_q;
  logic [vrt_pkg::VW-1:0] frame_cycle_q;
  logic [2:0] ctrl_q;

  wire ld_line = wr_data & (sel == vrt_pkg::SEL_LINE_PERIOD);
  wire ld_bstart = wr_data & (sel == vrt_pkg::SEL_BORDER_START);
  wire ld_dstart = wr_data & (sel == vrt_pkg::SEL_DISPLAY_START);
  wire ld_dend = wr_data & (sel == vrt_pkg::SEL_DISPLAY_END);
  wire ld_bend = wr_data & (sel == vrt_pkg::SEL_BORDER_END);
  wire ld_cstart = wr_data & (sel == vrt_pkg::SEL_CURSOR_START);
  wire ld_frame = wr_data & (sel == vrt_pkg::SEL_FRAME_CYCLE);
  wire ign_rsvd = wr_data & (sel == vrt_pkg::SEL_INTERLACE_RSVD);
  wire ign_test = wr_data & ((sel == vrt_pkg::SEL_TEST_A) | (sel == vrt_pkg::SEL_TEST_B));

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      line_period_q <= vrt_pkg::HREG_RESET;
    end else if (ld_line) begin
      line_period_q <= wval_h;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      border_start_q <= vrt_pkg::HREG_RESET;
    end else if (ld_bstart) begin
      border_start_q <= wval_h;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      display_start_q <= vrt_pkg::HREG_RESET;
    end else if (ld_dstart) begin
      display_start_q <= wval_h;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      display_end_q <= vrt_pkg::HREG_RESET;
    end else if (ld_dend) begin
      display_end_q <= wval_h;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      border_end_q <= vrt_pkg::HREG_RESET;
    end else if (ld_bend) begin
      border_end_q <= wval_h;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cursor_start_q <= vrt_pkg::HREG_RESET;
    end else if (ld_cstart) begin
      cursor_start_q <= wval_h;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      frame_cycle_q <= vrt_pkg::VREG_RESET;
    end else if (ld_frame) begin
      frame_cycle_q <= wval_v;
    end
  end

  // Control word: enable, resolution, interlace
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= vrt_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata_i[2:0];
    end
  end

  wire run = ctrl_q[vrt_pkg::CTRL_EN_BIT];
  wire high_resolution_mode = ctrl_q[vrt_pkg::CTRL_HIGH_RESOLUTION_MODE_BIT];
  wire ilace = ctrl_q[vrt_pkg::CTRL_ILACE_BIT];

  // Horizontal position
  logic [vrt_pkg::HCW-1:0] hcount;
  logic hwrap;
  // line of stored value plus 8
  wire [vrt_pkg::HCW-1:0] h_last = {1'b0, line_period_q} + vrt_pkg::LINE_OFS;

  vrt_counter #(
    .W(vrt_pkg::HCW)
  ) u_hcount (
    .clk_i(clk_i),
    .rst_n_i(rst_n_q),
    .run_i(run),
    .step_i(1'b1),
    .last_i(h_last),
    .count_o(hcount),
    .wrap_o(hwrap)
  );

  // Vertical position and field
  logic [vrt_pkg::VCW-1:0] vcount;
  logic vwrap;
  logic field_q;
  wire [vrt_pkg::VCW-1:0] v_base = {1'b0, frame_cycle_q};
  // frame of stored value plus 2
  wire [vrt_pkg::VCW-1:0] v_prog = v_base + vrt_pkg::FRAME_OFS;
  // interlaced fields of V+1 then V+2 rasters
  wire [vrt_pkg::VCW-1:0] v_last = (ilace & ~field_q) ? v_base : v_prog;

  vrt_counter #(
    .W(vrt_pkg::VCW)
  ) u_vcount (
    .clk_i(clk_i),
    .rst_n_i(rst_n_q),
    .run_i(run),
    .step_i(hwrap),
    .last_i(v_last),
    .count_o(vcount),
    .wrap_o(vwrap)
  );

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      field_q <= 1'b0;
    end else if (!run || !ilace) begin
      field_q <= 1'b0;
    end else if (vwrap) begin
      field_q <= ~field_q;
    end
  end

  // Horizontal compare points, relative to sync start
  // border start point
  wire [vrt_pkg::HCW-1:0] bstart_pt = {1'b0, border_start_q} + vrt_pkg::BORDER_OFS;
  wire [vrt_pkg::HCW-1:0] bend_pt = {1'b0, border_end_q} + vrt_pkg::BORDER_OFS;
  wire [vrt_pkg::HCW-1:0] dstart_pt = {1'b0, display_start_q} + vrt_pkg::DISPLAY_OFS;
  wire [vrt_pkg::HCW-1:0] dend_pt = {1'b0, display_end_q} + vrt_pkg::DISPLAY_OFS;
  wire [vrt_pkg::HCW-1:0] cstart_pt = {1'b0, cursor_start_q} + vrt_pkg::CURSOR_OFS;

  // End points are the first pixel outside the window
  wire border_win = run & (hcount >= bstart_pt) & (hcount < bend_pt);
  wire display_win = run & (hcount >= dstart_pt) & (hcount < dend_pt);
  wire cursor_win;

  vrt_cursor u_cursor (
    .clk_i(clk_i),
    .rst_n_i(rst_n_q),
    .run_i(run),
    .hcount_i(hcount),
    .start_i(cstart_pt),
    .high_resolution_mode_i(high_resolution_mode),
    .active_o(cursor_win)
  );

  // Line and field pulses at pixel zero
  wire line_start_d = run & (hcount == '0);
  wire frame_start_d = line_start_d & (vcount == '0);

  // Timing outputs, one clock behind the counters
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      line_start_o <= 1'b0;
      border_o <= 1'b0;
      display_o <= 1'b0;
      cursor_o <= 1'b0;
      frame_start_o <= 1'b0;
      field_odd_o <= 1'b0;
      hcount_o <= '0;
      vcount_o <= '0;
    end else begin
      line_start_o <= line_start_d;
      border_o <= border_win;
      display_o <= display_win;
      cursor_o <= cursor_win;
      frame_start_o <= frame_start_d;
      field_odd_o <= field_q;
      hcount_o <= hcount;
      vcount_o <= vcount;
    end
  end

  // Read data and answer
  wire [31:0] stat_word = {field_q, 1'b0, vcount, 1'b0, hcount};
  wire [31:0] ctrl_word = {29'h0000000, ctrl_q};
  wire [31:0] rd_word = (hit_ctrl & ~pwrite_i) ? ctrl_word :
    (hit_stat & ~pwrite_i) ? stat_word : 32'h00000000;
  wire unused_ok = ign_rsvd | ign_test;

  // Ready is raised for the first access cycle only
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else if (setup) begin
      pready_o <= 1'b1;
      pslverr_o <= ~mapped;
      prdata_o <= mapped ? rd_word : 32'h00000000;
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end
  end

  // Reserved and test codes are accepted silently
  logic sink_q;

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sink_q <= 1'b0;
    end else begin
      sink_q <= unused_ok;
    end
  end
endmodule : vrt_timing

// *** test/vrt_monitor.sv ***
// Purpose: Display side model that measures the raster it receives
// Assumes: One pixel per clock, windows sampled every pixel
// Notes: Each length is latched at the next line or field pulse
`timescale 1ns/10ps
module vrt_monitor (
  input wire logic clk_i, // Pixel clock
  input wire logic line_start_i, // Line pulse
  input wire logic frame_start_i, // Field pulse
  input wire logic display_i, // Video window
  input wire logic border_i, // Border window
  input wire logic cursor_i, // Cursor window
  output logic [15:0] line_len_o, // Pixels per line
  output logic [15:0] disp_len_o, // Video pixels per line
  output logic [15:0] brd_len_o, // Border pixels per line
  output logic [15:0] cur_len_o, // Cursor pixels per line
  output logic [15:0] frm_len_o // Lines per field
);
  logic [15:0] n_q, d_q, b_q, c_q, f_q;
  always_ff @(posedge clk_i) begin
    if (line_start_i) begin
      line_len_o <= n_q;
      disp_len_o <= d_q;
      brd_len_o <= b_q;
      cur_len_o <= c_q;
    end
    if (frame_start_i) frm_len_o <= f_q;
    n_q <= line_start_i ? 16'h1 : n_q + 16'h1;
    d_q <= (line_start_i ? 16'h0 : d_q) + {15'h0, display_i};
    b_q <= (line_start_i ? 16'h0 : b_q) + {15'h0, border_i};
    c_q <= (line_start_i ? 16'h0 : c_q) + {15'h0, cursor_i};
    f_q <= frame_start_i ? 16'h1 : f_q + {15'h0, line_start_i};
  end
endmodule : vrt_monitor

// *** test/vrt_timing_properties.sv ***
// Purpose: Port level checks of the raster timing block
// Assumes: Timing registers change only while timing is stopped
// Notes: Shadows the data port writes to know the programmed edges
`timescale 1ns/10ps
module vrt_timing_chk (
  input wire logic clk_i, // Clock
  input wire logic resetn_i, // Reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [11:0] paddr_i, // APB address
  input wire logic [31:0] pwdata_i, // APB write data
  input wire logic [31:0] prdata_o, // APB read data
  input wire logic pready_o, // APB ready
  input wire logic pslverr_o, // APB error
  input wire logic line_start_o, // Line pulse
  input wire logic border_o, // Border window
  input wire logic display_o, // Video window
  input wire logic cursor_o, // Cursor window
  input wire logic [vrt_pkg::HCW-1:0] hcount_o, // Pixel position
  input wire logic field_odd_o, // Second field
  input wire logic [vrt_pkg::VCW-1:0] vcount_o // Raster position
);
  logic [13:0] sh_q [8];
  logic [12:0] fc_q;
  logic [2:0] ctl_q;
  logic [3:0] age_q;
  logic [5:0] cl_q;
  wire wr = psel_i && penable_i && pready_o && pwrite_i;
  wire dw = wr && paddr_i == vrt_pkg::DATA_OFF;
  wire ok = age_q > 4'h4;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sh_q <= '{default: '0};
      fc_q <= '0;
      ctl_q <= '0;
      age_q <= '0;
      cl_q <= '0;
    end else begin
      if (dw && pwdata_i[31:27] == 5'h10) sh_q[pwdata_i[26:24]] <= pwdata_i[13:0];
      if (dw && pwdata_i[31:24] == vrt_pkg::SEL_FRAME_CYCLE) fc_q <= pwdata_i[12:0];
      if (wr && paddr_i == vrt_pkg::CTRL_OFF) ctl_q <= pwdata_i[2:0];
      age_q <= !ctl_q[0] ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
      cl_q <= cursor_o ? cl_q + 6'h1 : 6'h0;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  property p_border; ok |-> border_o == (hcount_o >= sh_q[2] + vrt_pkg::BORDER_OFS
    && hcount_o < sh_q[5] + vrt_pkg::BORDER_OFS); endproperty
  a_border: assert property (p_border) else $error("border window wrong");
  property p_disp; ok |-> display_o == (hcount_o >= sh_q[3] + vrt_pkg::DISPLAY_OFS
    && hcount_o < sh_q[4] + vrt_pkg::DISPLAY_OFS); endproperty
  a_disp: assert property (p_disp) else $error("display window wrong");
  property p_cstart; ok && $rose(cursor_o) |-> hcount_o == sh_q[6] + vrt_pkg::CURSOR_OFS;
  endproperty
  a_cstart: assert property (p_cstart) else $error("cursor start wrong");
  property p_clen; ok && $fell(cursor_o) |-> cl_q == (ctl_q[1] ? vrt_pkg::CURSOR_W_HIGH_RESOLUTION_MODE
    : vrt_pkg::CURSOR_W_NORMAL); endproperty
  a_clen: assert property (p_clen) else $error("cursor width wrong");
  property p_step; ok && hcount_o != 0 |-> hcount_o == $past(hcount_o) + 15'h1; endproperty
  a_step: assert property (p_step) else $error("pixel count skipped");
  property p_wrap; ok && hcount_o == 0 |-> $past(hcount_o) == sh_q[0] + vrt_pkg::LINE_OFS;
  endproperty
  a_wrap: assert property (p_wrap) else $error("line length wrong");
  property p_line; ok |-> line_start_o == (hcount_o == 0); endproperty
  a_line: assert property (p_line) else $error("line pulse misplaced");
  property p_frame; ok && line_start_o && vcount_o == 0 |-> $past(vcount_o) ==
    ((ctl_q[2] && !$past(field_odd_o)) ? {1'b0, fc_q} : fc_q + vrt_pkg::FRAME_OFS);
  endproperty
  a_frame: assert property (p_frame) else $error("frame length wrong");
  property p_field; ok && line_start_o && vcount_o == 0 |->
    field_odd_o == (ctl_q[2] && !$past(field_odd_o)); endproperty
  a_field: assert property (p_field) else $error("field order wrong");
  property p_rdy; psel_i && !penable_i |=> pready_o ##1 !pready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("ready not one pulse");
  property p_err; pready_o |-> pslverr_o == !(paddr_i == vrt_pkg::DATA_OFF ||
    paddr_i == vrt_pkg::CTRL_OFF || (paddr_i == vrt_pkg::STAT_OFF && !pwrite_i)); endproperty
  a_err: assert property (p_err) else $error("error response wrong");
endmodule : vrt_timing_chk
bind vrt_timing vrt_timing_chk i_vrt_timing_chk (.clk_i(clk_i), .resetn_i(resetn_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .line_start_o(line_start_o), .border_o(border_o), .display_o(display_o),
  .cursor_o(cursor_o), .field_odd_o(field_odd_o), .hcount_o(hcount_o), .vcount_o(vcount_o));

// *** test/vrt_timing_test.sv ***
// Purpose: Self checking bench for the raster timing block
// Assumes: Timing registers are loaded while timing is stopped
// Notes: A display model measures every window of the raster
`timescale 1ns/10ps
module vrt_timing_test;
  logic clk_i, resetn, psel, penable, pwrite, rd_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic pready, pslverr, ls, brd, disp, cur, fs;
  logic [15:0] m_line, m_disp, m_brd, m_cur, m_frm;
  int err_count = 0;
  int num_checks = 0;
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  vrt_timing i_vrt_timing (.clk_i(clk_i), .resetn_i(resetn), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .line_start_o(ls),
    .border_o(brd), .display_o(disp), .cursor_o(cur), .frame_start_o(fs),
    .field_odd_o(), .hcount_o(), .vcount_o());
  vrt_monitor i_vrt_monitor (.clk_i(clk_i), .line_start_i(ls), .frame_start_i(fs),
    .display_i(disp), .border_i(brd), .cursor_i(cur), .line_len_o(m_line),
    .disp_len_o(m_disp), .brd_len_o(m_brd), .cur_len_o(m_cur), .frm_len_o(m_frm));
  task print_verdict;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    // Answer taken at the edge that samples pready high
    @(posedge clk_i);
    n = 1;
    while (pready !== 1'b1 && n < 16) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 16) chk(32'h0, 32'h1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] c, input logic [13:0] v);
    apb(1'b1, vrt_pkg::DATA_OFF, {c, 10'h000, v});
  endtask : wr
  task run(input logic [13:0] bs, ds, de, be, cs, input logic hr, il);
    apb(1'b1, vrt_pkg::CTRL_OFF, 32'h0);
    wr(vrt_pkg::SEL_LINE_PERIOD, 14'd92);
    wr(vrt_pkg::SEL_BORDER_START, bs);
    wr(vrt_pkg::SEL_DISPLAY_START, ds);
    wr(vrt_pkg::SEL_DISPLAY_END, de);
    wr(vrt_pkg::SEL_BORDER_END, be);
    wr(vrt_pkg::SEL_CURSOR_START, cs);
    wr(vrt_pkg::SEL_FRAME_CYCLE, 14'd3);
    apb(1'b1, vrt_pkg::CTRL_OFF, {29'h0, il, hr, 1'b1});
    // Reserved and test codes stay untouched; an unknown code is ignored
    wr(8'hFF, 14'h3FFE);
    chk({31'h0, rd_err}, 32'h0);
    repeat (700) @(posedge clk_i);
    apb(1'b0, vrt_pkg::STAT_OFF, 32'h0);
    chk({31'h0, rd_data[14:0] <= 15'd92 + vrt_pkg::LINE_OFS}, 32'h1);
    chk({31'h0, rd_data[29:16] <= 14'd3 + vrt_pkg::FRAME_OFS}, 32'h1);
    chk({29'h0, rd_data[31] & ~il, rd_data[30], rd_data[15]}, 32'h0);
    chk({16'h0, m_line}, 32'd92 + vrt_pkg::LINE_OFS + 1);
    chk({16'h0, m_disp}, {18'h0, de - ds});
    chk({16'h0, m_brd}, {18'h0, be - bs});
    chk({16'h0, m_cur}, hr ? 32'd16 : 32'd32);
    // Interlaced frame of 2*3+3 rasters: first field 4, second 5
    chk({16'h0, m_frm}, il ? 32'd3 + 1 : 32'd3 + vrt_pkg::FRAME_OFS + 1);
    if (il) begin
      repeat (500) @(posedge clk_i);
      chk({16'h0, m_frm}, 32'd3 + vrt_pkg::FRAME_OFS + 1);
    end
  endtask : run
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge clk_i);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_i);
    apb(1'b0, vrt_pkg::CTRL_OFF, 32'h0);
    chk(rd_data, {29'h0, vrt_pkg::CTRL_RESET});
    apb(1'b1, vrt_pkg::CTRL_OFF, 32'h6);
    apb(1'b0, vrt_pkg::CTRL_OFF, 32'h0);
    chk(rd_data, 32'h6);
    apb(1'b0, 12'h00C, 32'h0);
    chk({31'h0, rd_err}, 32'h1);
    apb(1'b1, vrt_pkg::STAT_OFF, 32'h0);
    chk({31'h0, rd_err}, 32'h1);
    apb(1'b0, vrt_pkg::DATA_OFF, 32'h0);
    chk(rd_data, 32'h0);
    run(14'd8, 14'd12, 14'd52, 14'd68, 14'd23, 1'b0, 1'b0);
    // No border: edges follow the video window
    run(14'd18, 14'd12, 14'd52, 14'd58, 14'd25, 1'b1, 1'b0);
    run(14'd8, 14'd12, 14'd52, 14'd68, 14'd23, 1'b0, 1'b1);
    print_verdict;
  end
  initial begin
    #500000;
    err_count++;
    print_verdict;
  end
endmodule : vrt_timing_test
